// ===== hdl/isr_pkg.sv
// Shared constants, field layouts and carriers of the sensor readout control block
package isr_pkg;

	// Upload word: 4 address bits then 12 data bits, both MSB first
	localparam int ISR_WORD_BITS = 16;
	localparam int ISR_ADDR_BITS = 4;
	localparam int ISR_DATA_BITS = 12;

	// Register addresses within the upload word
	localparam logic [3:0] ISR_A_AMP    = 4'h0;
	localparam logic [3:0] ISR_A_COARSE = 4'h1;
	localparam logic [3:0] ISR_A_FINE   = 4'h2;
	localparam logic [3:0] ISR_A_DARK   = 4'h3;
	localparam logic [3:0] ISR_A_ADC    = 4'h4;
	localparam logic [3:0] ISR_A_NPIX   = 4'h5;
	localparam logic [3:0] ISR_A_NLINES = 4'h6;

	// Output amplifier control fields
	localparam int ISR_AMP_GAIN_LSB = 0;
	localparam int ISR_AMP_UNITY    = 4;
	localparam int ISR_AMP_ONE_OUT  = 5;
	localparam int ISR_AMP_STANDBY  = 6;
	localparam int ISR_AMP_DLY_LSB  = 7;

	// Converter control fields
	localparam int ISR_ADC_STBY_1   = 0;
	localparam int ISR_ADC_STBY_2   = 1;
	localparam int ISR_ADC_SINGLE   = 2;
	localparam int ISR_ADC_SWAP     = 3;
	localparam int ISR_ADC_EXT_CLK  = 4;
	localparam int ISR_ADC_TRISTATE = 5;
	localparam int ISR_ADC_DLY_LSB  = 6;
	localparam int ISR_ADC_GAMMA    = 9;
	localparam int ISR_ADC_INVERT   = 10;

	// Values after reset
	localparam logic [11:0] ISR_RST_AMP    = 12'h000;
	localparam logic [6:0]  ISR_RST_COARSE = 7'h00;
	localparam logic [7:0]  ISR_RST_FINE   = 8'h80;
	localparam logic [11:0] ISR_RST_DARK   = 12'h000;
	localparam logic [11:0] ISR_RST_ADC    = 12'h000;
	localparam logic [11:0] ISR_RST_NPIX   = 12'h000;
	localparam logic [11:0] ISR_RST_NLINES = 12'h000;

	// Timing
	localparam int ISR_SYS_CLK_MHZ   = 250;
	localparam int ISR_DLY_BASE_PS   = 1700;
	localparam int ISR_ROW_BLANK_CYC = 142;
	localparam int ISR_ANA_DLY_TWO   = 4;
	localparam int ISR_ANA_DLY_ONE   = 5;
	localparam int ISR_ADC_LATENCY   = 2;

	typedef enum logic [2:0] {ISR_IDLE, ISR_SUSPEND, ISR_BLANK, ISR_READ, ISR_EOL} isr_state_t;

	// Settings that steer the analog side, grouped for the top-level port
	typedef struct packed {
		logic [3:0] amp_gain;
		logic       amp_unity;
		logic       path_b_standby;
		logic       amp_standby;
		logic [2:0] amp_clk_delay;
		logic       amp_clk_invert;
		logic [2:0] adc_clk_delay;
		logic       adc_clk_invert;
		logic [6:0] coarse_dac;
		logic [7:0] fine_dac;
		logic [11:0] dark_dac;
		logic       dark_on_buses;
		logic       dark_on_reset_buses;
		logic       adc_a_standby;
		logic       adc_b_standby;
		logic       adc_ext_clk;
	} isr_analog_ctl_t;

endpackage : isr_pkg

// ===== hdl/isr_readout.sv
// Sensor readout control: serial upload, settings, sequencer handshake, ADC output path
// How it works
// - Gain applies only when unity bit clear
// - Single output muxes both buses, idles path B
// - Standby bit idles whole output amplifier
// - Three-bit clock delay codes, top half inverts
// - Coarse offset code maps monotonically to black
// - Dark code drives buses in calibration, NDR
// - Each converter has its own standby bit
// - Dual mode interleaves both converters onto bus
// - Swap delays output or picks converter
// - Converter clock internal half-rate or external pin
// - Output disable floats all ten pixel outputs
// - Gamma or linear coding, optional bit inversion
// - Sixteen chained shift cells, one serial clock
// - Register clock rise copies word into register
// - Pixel-valid spans row, end-of-line follows fall
// - End-of-frame after last line finishes reading
// - Analog pixel valid four or five clocks later
// - Converter samples falling edge, two-clock latency
// - Serial data shifts on serial clock rise
`timescale 1ns/10ps
module isr_readout #(
	parameter int PIX_BITS = 10
) (
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	input  wire logic                    spi_clk,
	input  wire logic                    spi_data,
	input  wire logic                    reg_clock,
	input  wire logic                    line_clock,
	input  wire logic                    frame_start,
	input  wire logic                    ndr_mode,
	input  wire logic                    adc_clk_ext,
	input  wire logic [PIX_BITS-1:0]     adc_a_raw,
	input  wire logic [PIX_BITS-1:0]     adc_b_raw,
	output logic                         pixel_valid,
	output logic                         end_of_line,
	output logic                         end_of_frame,
	output logic                         analog_output_a_valid,
	output logic                         analog_output_b_valid,
	output logic [PIX_BITS-1:0]          pixel_out,
	output logic [PIX_BITS-1:0]          pixel_oe,
	output isr_pkg::isr_analog_ctl_t     analog_ctl
);
	import isr_pkg::*;

	localparam int ANA_PIPE = ISR_ANA_DLY_ONE;

	// Serial clock domain: only the chain lives here
	typedef struct packed {
		logic [ISR_WORD_BITS-1:0] chain;
	} isr_spi_t;

	typedef struct packed {
		logic [2:0]            rclk_sync;
		logic                  rclk_lvl;
		logic [2:0]            xclk_sync;
		logic                  xclk_lvl;
		logic [11:0]           amp;
		logic [6:0]            coarse;
		logic [7:0]            fine;
		logic [11:0]           dark;
		logic [11:0]           adc;
		logic [11:0]           npix;
		logic [11:0]           nlines;
		isr_state_t            state;
		logic [11:0]           blank_cnt;
		logic [11:0]           pix_cnt;
		logic [11:0]           line_cnt;
		logic                  frame_active;
		logic                  pvalid;
		logic                  eol;
		logic                  eof;
		logic [ANA_PIPE-1:0]   ana_pipe;
		logic                  adc_ph;
		logic [PIX_BITS-1:0]   a_s1;
		logic [PIX_BITS-1:0]   a_s2;
		logic [PIX_BITS-1:0]   b_s1;
		logic [PIX_BITS-1:0]   b_s2;
		logic [PIX_BITS-1:0]   mux_word;
		logic [PIX_BITS-1:0]   mux_word_d;
		logic [PIX_BITS-1:0]   dout;
	} isr_sys_t;

	isr_spi_t spi_q;
	isr_spi_t next_spi_q;
	isr_sys_t q;
	isr_sys_t next_q;

	// Gamma law: steeper slope in the dark quarter, flatter in the bright three quarters
	function automatic logic [PIX_BITS-1:0] gamma_map(input logic [PIX_BITS-1:0] x);
		logic [PIX_BITS-1:0] knee;
		knee = PIX_BITS'(1 << (PIX_BITS - 2));
		if (x < knee)
			gamma_map = PIX_BITS'(x << 1);
		else
			gamma_map = PIX_BITS'((x >> 1) + (knee >> 1) + knee);
	endfunction : gamma_map

	always_comb
	begin
		next_spi_q = spi_q;
		next_spi_q.chain = {spi_q.chain[ISR_WORD_BITS-2:0], spi_data};
	end

	// The chain runs only while the controller clocks it; the word is static once
	// the register clock rises, so the system side may sample it after its own sync
	always_ff @(posedge spi_clk or posedge rst)
	begin
		if (rst)
			spi_q <= '0;
		else
			spi_q <= next_spi_q;
	end

	logic                     rclk_rise;
	logic                     xclk_rise;
	logic                     xclk_fall;
	logic                     adc_fall;
	logic                     adc_edge;
	logic [ISR_ADDR_BITS-1:0] up_addr;
	logic [ISR_DATA_BITS-1:0] up_data;
	logic                     single_adc;
	logic                     swap;
	logic                     ext_clk;
	logic                     last_line;
	logic [PIX_BITS-1:0]      sel_word;
	logic [PIX_BITS-1:0]      coded;

	always_comb
	begin
		next_q = q;
		up_addr = spi_q.chain[ISR_WORD_BITS-1 -: ISR_ADDR_BITS];
		up_data = spi_q.chain[ISR_DATA_BITS-1:0];
		single_adc = q.adc[ISR_ADC_SINGLE];
		swap = q.adc[ISR_ADC_SWAP];
		ext_clk = q.adc[ISR_ADC_EXT_CLK];

		// Pin synchronisers: a level counts once stages two and three agree
		next_q.rclk_sync = {q.rclk_sync[1:0], reg_clock};
		next_q.xclk_sync = {q.xclk_sync[1:0], adc_clk_ext};
		rclk_rise = 1'b0;
		if (q.rclk_sync[2] == q.rclk_sync[1])
		begin
			next_q.rclk_lvl = q.rclk_sync[2];
			rclk_rise = q.rclk_sync[2] & ~q.rclk_lvl;
		end
		xclk_rise = 1'b0;
		xclk_fall = 1'b0;
		if (q.xclk_sync[2] == q.xclk_sync[1])
		begin
			next_q.xclk_lvl = q.xclk_sync[2];
			xclk_rise = q.xclk_sync[2] & ~q.xclk_lvl;
			xclk_fall = ~q.xclk_sync[2] & q.xclk_lvl;
		end

		// Register transfer; unknown addresses are dropped
		if (rclk_rise)
		begin
			unique case (up_addr)
				ISR_A_AMP:    next_q.amp = up_data;
				ISR_A_COARSE: next_q.coarse = up_data[6:0];
				ISR_A_FINE:   next_q.fine = up_data[7:0];
				ISR_A_DARK:   next_q.dark = up_data;
				ISR_A_ADC:    next_q.adc = up_data;
				ISR_A_NPIX:   next_q.npix = up_data;
				ISR_A_NLINES: next_q.nlines = up_data;
				default:      next_q.amp = q.amp;
			endcase
		end

		// Sequencer
		next_q.eol = 1'b0;
		next_q.eof = 1'b0;
		last_line = (q.line_cnt == q.nlines);
		if (frame_start)
		begin
			next_q.frame_active = 1'b1;
			next_q.line_cnt = '0;
		end
		unique case (q.state)
			ISR_IDLE:
			begin
				if (line_clock && (q.frame_active || frame_start))
					next_q.state = ISR_SUSPEND;
			end
			ISR_SUSPEND:
			begin
				if (!line_clock)
				begin
					next_q.state = ISR_BLANK;
					next_q.blank_cnt = '0;
				end
			end
			ISR_BLANK:
			begin
				if (line_clock)
					next_q.state = ISR_SUSPEND;
				else if (q.blank_cnt == 12'(ISR_ROW_BLANK_CYC - 1))
				begin
					next_q.state = ISR_READ;
					next_q.pvalid = 1'b1;
					next_q.pix_cnt = '0;
				end
				else
					next_q.blank_cnt = q.blank_cnt + 12'h001;
			end
			ISR_READ:
			begin
				if (q.pix_cnt == q.npix)
				begin
					next_q.pvalid = 1'b0;
					next_q.state = ISR_EOL;
				end
				else
					next_q.pix_cnt = q.pix_cnt + 12'h001;
			end
			ISR_EOL:
			begin
				next_q.eol = 1'b1;
				if (last_line && !frame_start)
				begin
					next_q.eof = 1'b1;
					next_q.frame_active = 1'b0;
				end
				else if (!frame_start)
					next_q.line_cnt = q.line_cnt + 12'h001;
				next_q.state = line_clock ? ISR_SUSPEND : ISR_IDLE;
			end
		endcase

		// Analog valid trails the row start by 4 or 5 cycles
		next_q.ana_pipe = {q.ana_pipe[ANA_PIPE-2:0], q.pvalid};

		// Converter clock: half rate internal, or the external pin
		next_q.adc_ph = ~q.adc_ph;
		adc_fall = ext_clk ? xclk_fall : q.adc_ph;
		adc_edge = ext_clk ? (xclk_fall | xclk_rise) : 1'b1;

		// Two-stage pipelines clocked on the falling converter edge
		if (adc_fall)
		begin
			next_q.a_s1 = adc_a_raw;
			next_q.a_s2 = q.a_s1;
			next_q.b_s1 = adc_b_raw;
			next_q.b_s2 = q.b_s1;
		end

		// Interleave: A on falling edges, B on rising edges
		if (adc_edge)
		begin
			next_q.mux_word = adc_fall ? q.a_s2 : q.b_s2;
			next_q.mux_word_d = q.mux_word;
		end

		if (single_adc)
			sel_word = swap ? q.b_s2 : q.a_s2;
		else
			sel_word = swap ? q.mux_word_d : q.mux_word;

		coded = q.adc[ISR_ADC_GAMMA] ? gamma_map(sel_word) : sel_word;
		next_q.dout = q.adc[ISR_ADC_INVERT] ? ~coded : coded;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			q <= '0;
			q.amp <= ISR_RST_AMP;
			q.coarse <= ISR_RST_COARSE;
			q.fine <= ISR_RST_FINE;
			q.dark <= ISR_RST_DARK;
			q.adc <= ISR_RST_ADC;
			q.npix <= ISR_RST_NPIX;
			q.nlines <= ISR_RST_NLINES;
			q.state <= ISR_IDLE;
		end
		else
			q <= next_q;
	end

	assign pixel_valid = q.pvalid;
	assign end_of_line = q.eol;
	assign end_of_frame = q.eof;
	assign pixel_out = q.dout;
	assign pixel_oe = {PIX_BITS{~q.adc[ISR_ADC_TRISTATE]}};

	// In single-output mode both buses share output A, which needs one extra cycle
	assign analog_output_a_valid = q.amp[ISR_AMP_ONE_OUT] ? q.ana_pipe[ISR_ANA_DLY_ONE-1]
		: q.ana_pipe[ISR_ANA_DLY_TWO-1];
	assign analog_output_b_valid = ~q.amp[ISR_AMP_ONE_OUT] & q.ana_pipe[ISR_ANA_DLY_TWO-1];

	always_comb
	begin
		analog_ctl.amp_gain = q.amp[ISR_AMP_UNITY] ? 4'h0 : q.amp[ISR_AMP_GAIN_LSB +: 4];
		analog_ctl.amp_unity = q.amp[ISR_AMP_UNITY];
		analog_ctl.path_b_standby = q.amp[ISR_AMP_ONE_OUT] | q.amp[ISR_AMP_STANDBY];
		analog_ctl.amp_standby = q.amp[ISR_AMP_STANDBY];
		analog_ctl.amp_clk_delay = q.amp[ISR_AMP_DLY_LSB +: 3];
		analog_ctl.amp_clk_invert = q.amp[ISR_AMP_DLY_LSB + 2];
		analog_ctl.adc_clk_delay = q.adc[ISR_ADC_DLY_LSB +: 3];
		analog_ctl.adc_clk_invert = q.adc[ISR_ADC_DLY_LSB + 2];
		analog_ctl.coarse_dac = q.coarse;
		analog_ctl.fine_dac = q.fine;
		analog_ctl.dark_dac = q.dark;
		// Output-stage calibration runs during row blanking
		analog_ctl.dark_on_buses = (q.state == ISR_BLANK) | ndr_mode;
		analog_ctl.dark_on_reset_buses = ndr_mode;
		analog_ctl.adc_a_standby = q.adc[ISR_ADC_STBY_1];
		analog_ctl.adc_b_standby = q.adc[ISR_ADC_STBY_2];
		analog_ctl.adc_ext_clk = q.adc[ISR_ADC_EXT_CLK];
	end

endmodule : isr_readout

// ===== tb/isr_readout_sva.sv
// Port assertions for the sensor readout control block
`timescale 1ns/10ps
module isr_readout_sva
	import isr_pkg::*;
#(
	parameter int PIX_BITS = 10
) (
	input wire logic                clk_sys,
	input wire logic                rst,
	input wire logic                line_clock,
	input wire logic                pixel_valid,
	input wire logic                end_of_line,
	input wire logic                end_of_frame,
	input wire logic                analog_output_a_valid,
	input wire logic                analog_output_b_valid,
	input wire logic [PIX_BITS-1:0] pixel_oe,
	input wire isr_analog_ctl_t     analog_ctl
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence s_row_start;
		$rose(pixel_valid);
	endsequence

	property p_eol_after_fall;
		$fell(pixel_valid) |-> ##[0:1] end_of_line;
	endproperty
	property p_eol_pulse;
		end_of_line |=> !end_of_line;
	endproperty
	property p_eof_on_eol;
		end_of_frame |-> end_of_line && !pixel_valid;
	endproperty
	property p_two_out;
		s_row_start ##0 !analog_ctl.path_b_standby |-> ##4 $rose(analog_output_b_valid);
	endproperty
	property p_one_out;
		s_row_start ##0 analog_ctl.path_b_standby |-> ##5 $rose(analog_output_a_valid);
	endproperty
	property p_b_idle;
		analog_ctl.path_b_standby |-> !analog_output_b_valid;
	endproperty
	property p_unity;
		analog_ctl.amp_unity |-> analog_ctl.amp_gain == 4'h0;
	endproperty
	property p_clk_inv;
		analog_ctl.amp_clk_invert == analog_ctl.amp_clk_delay[2]
			&& analog_ctl.adc_clk_invert == analog_ctl.adc_clk_delay[2];
	endproperty
	property p_oe;
		pixel_oe == '0 || pixel_oe == '1;
	endproperty
	// Blanking keeps readout off well past the line clock
	property p_blank;
		$fell(line_clock) |-> !pixel_valid [*8];
	endproperty

	a_eol_after_fall: assert property (p_eol_after_fall) else $error("eol missing");
	a_eol_pulse: assert property (p_eol_pulse) else $error("eol too long");
	a_eof_on_eol: assert property (p_eof_on_eol) else $error("eof misplaced");
	a_two_out: assert property (p_two_out) else $error("output b late");
	a_one_out: assert property (p_one_out) else $error("output a late");
	a_b_idle: assert property (p_b_idle) else $error("path b active");
	a_unity: assert property (p_unity) else $error("gain not bypassed");
	a_clk_inv: assert property (p_clk_inv) else $error("clock invert wrong");
	a_oe: assert property (p_oe) else $error("partial enable");
	a_blank: assert property (p_blank) else $error("no blanking");
endmodule : isr_readout_sva

bind isr_readout isr_readout_sva #(.PIX_BITS(PIX_BITS)) sva_u (
	.clk_sys(clk_sys),
	.rst(rst),
	.line_clock(line_clock),
	.pixel_valid(pixel_valid),
	.end_of_line(end_of_line),
	.end_of_frame(end_of_frame),
	.analog_output_a_valid(analog_output_a_valid),
	.analog_output_b_valid(analog_output_b_valid),
	.pixel_oe(pixel_oe),
	.analog_ctl(analog_ctl)
);

// ===== tb/isr_ctrl_model.sv
// Camera controller model driving upload and sequencer pins
`timescale 1ns/10ps
module isr_ctrl_model (
	input  wire logic clk_sys,
	output logic      spi_clk,
	output logic      spi_data,
	output logic      reg_clock,
	output logic      line_clock,
	output logic      frame_start,
	output logic      adc_clk_ext
);
	initial
	begin
		spi_clk = 1'b0;
		spi_data = 1'b0;
		reg_clock = 1'b0;
		line_clock = 1'b0;
		frame_start = 1'b0;
		adc_clk_ext = 1'b0;
	end

	logic [1:0] xdiv = 2'b00;

	// Converter clock always supplied at an eighth of the system rate, so each
	// level outlasts the pin synchroniser's agreement window
	always @(posedge clk_sys)
	begin
		xdiv <= xdiv + 2'b01;
		if (xdiv == 2'b11)
			adc_clk_ext <= ~adc_clk_ext;
	end

	// Serial clock stands still between words
	task automatic upload(input logic [3:0] a, input logic [11:0] d);
		logic [15:0] w;
		w = {a, d};
		#1.3;
		for (int i = 15; i >= 0; i--)
		begin
			spi_data = w[i];
			#3 spi_clk = 1'b1;
			#3 spi_clk = 1'b0;
		end
		spi_data = ~w[0];
		@(posedge clk_sys);
		reg_clock <= 1'b1;
		repeat (6) @(posedge clk_sys);
		reg_clock <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask : upload

	task automatic frame();
		@(posedge clk_sys);
		frame_start <= 1'b1;
		repeat (3) @(posedge clk_sys);
		frame_start <= 1'b0;
	endtask : frame

	task automatic line();
		@(posedge clk_sys);
		line_clock <= 1'b1;
		@(posedge clk_sys);
		line_clock <= 1'b0;
	endtask : line
endmodule : isr_ctrl_model

// ===== tb/tb.sv
// Self-checking bench for the sensor readout control block
`timescale 1ns/10ps
`define CHK(nm, ex, gt) \
	begin \
		comparisons++; \
		if ((gt) !== (ex)) \
		begin \
			num_errors++; \
			$display("BAD %s expected %0h seen %0h", nm, ex, gt); \
		end \
	end
module tb;
	import isr_pkg::*;
	logic            clk_sys;
	logic            rst;
	logic            ndr_mode;
	logic [9:0]      adc_a_raw;
	logic [9:0]      adc_b_raw;
	logic            spi_clk, spi_data, reg_clock, line_clock, frame_start, adc_clk_ext;
	logic            pixel_valid, end_of_line, end_of_frame, a_valid, b_valid;
	logic [9:0]      pixel_oe;
	isr_analog_ctl_t analog_ctl;
	isr_analog_ctl_t saved;
	int              num_errors = 0;
	int              comparisons = 0;
	logic [31:0]     rng = 32'h2f0d;
	logic [12:0]     exp_q[$];
	logic [12:0]     exp_row;
	logic [11:0]     pv_len = 12'h000;
	logic            hold_raw = 1'b0;
	logic [31:0]     cyc = 32'h0000_0000;
	logic [9:0]      pix_out, pa, pb, p0, p1, p2;

	isr_ctrl_model ctl_u (.clk_sys(clk_sys), .spi_clk(spi_clk), .spi_data(spi_data),
		.reg_clock(reg_clock), .line_clock(line_clock), .frame_start(frame_start),
		.adc_clk_ext(adc_clk_ext));
	isr_readout dut_u (.clk_sys(clk_sys), .rst(rst), .spi_clk(spi_clk), .spi_data(spi_data),
		.reg_clock(reg_clock), .line_clock(line_clock), .frame_start(frame_start),
		.ndr_mode(ndr_mode), .adc_clk_ext(adc_clk_ext), .adc_a_raw(adc_a_raw),
		.adc_b_raw(adc_b_raw), .pixel_valid(pixel_valid), .end_of_line(end_of_line),
		.end_of_frame(end_of_frame), .analog_output_a_valid(a_valid),
		.analog_output_b_valid(b_valid), .pixel_out(pix_out), .pixel_oe(pixel_oe),
		.analog_ctl(analog_ctl));

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xorshift

	function automatic logic [9:0] exp_gamma(input logic [9:0] x);
		if (x < 10'h100)
			return {x[8:0], 1'b0};
		return (x >> 1) + 10'h180;
	endfunction : exp_gamma

	// Lets the converter pipeline fill, then aligns to an even cycle
	task automatic settle();
		repeat (8) @(posedge clk_sys);
		while (cyc[0] !== 1'b0)
			@(posedge clk_sys);
	endtask : settle

	always #2 clk_sys = ~clk_sys;

	// Top bit forced apart so the two converters stay distinguishable on the bus
	always @(posedge clk_sys)
	begin
		rng <= xorshift(rng);
		cyc <= cyc + 32'h0000_0001;
		if (!hold_raw)
		begin
			adc_a_raw <= rng[9:0];
			adc_b_raw <= rng[9:0] ^ {1'b1, rng[18:10]};
		end
	end

	always @(posedge clk_sys)
	begin
		if (pixel_valid === 1'b1)
			pv_len <= pv_len + 12'h001;
		if (end_of_line === 1'b1)
		begin
			exp_row = exp_q.pop_front();
			`CHK("row length", exp_row[11:0], pv_len)
			`CHK("frame end", exp_row[12], end_of_frame)
			pv_len <= 12'h000;
		end
	end

	// Optional second line clock inside blanking must restart the wait
	task automatic row(input logic [11:0] npix, input logic eof, input int pre);
		int k;
		exp_q.push_back({eof, npix + 12'h001});
		ctl_u.line();
		if (pre > 0)
		begin
			repeat (pre) @(posedge clk_sys);
			ctl_u.line();
		end
		k = 0;
		while (pixel_valid !== 1'b1 && k < 400)
		begin
			if (k == 50)
				`CHK("calib dark", 1'b1, analog_ctl.dark_on_buses)
			@(posedge clk_sys);
			k++;
		end
		`CHK("blank span", 1'b1, k inside {[142:145]})
		repeat (npix + 8) @(posedge clk_sys);
	endtask : row

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		tally_and_finish();
	end

	initial
	begin
		clk_sys = 1'b0;
		rst = 1'b1;
		ndr_mode = 1'b0;
		adc_a_raw = 10'h000;
		adc_b_raw = 10'h000;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		`CHK("fine reset", 8'h80, analog_ctl.fine_dac)
		`CHK("oe reset", 10'h3ff, pixel_oe)
		ctl_u.upload(ISR_A_AMP, 12'h015);
		`CHK("unity gain", 4'h0, analog_ctl.amp_gain)
		ctl_u.upload(ISR_A_AMP, 12'h265);
		`CHK("gain", 4'h5, analog_ctl.amp_gain)
		`CHK("path b", 1'b1, analog_ctl.path_b_standby)
		`CHK("amp stby", 1'b1, analog_ctl.amp_standby)
		`CHK("amp delay", 3'h4, analog_ctl.amp_clk_delay)
		ctl_u.upload(ISR_A_COARSE, 12'h07f);
		`CHK("coarse", 7'h7f, analog_ctl.coarse_dac)
		ctl_u.upload(ISR_A_DARK, 12'habc);
		`CHK("dark", 12'habc, analog_ctl.dark_dac)
		ctl_u.upload(ISR_A_ADC, 12'h023);
		`CHK("adc stby", 2'h3, {analog_ctl.adc_a_standby, analog_ctl.adc_b_standby})
		`CHK("oe off", 10'h000, pixel_oe)
		ctl_u.upload(ISR_A_ADC, 12'h1d0);
		`CHK("ext clk", 1'b1, analog_ctl.adc_ext_clk)
		`CHK("adc delay", 3'h7, analog_ctl.adc_clk_delay)
		`CHK("oe on", 10'h3ff, pixel_oe)
		saved = analog_ctl;
		ctl_u.upload(4'h7, 12'hfff);
		`CHK("unmapped", saved, analog_ctl)
		$display("test registers done");
		ctl_u.upload(ISR_A_NLINES, 12'h001);
		for (int i = 0; i < 2; i++)
		begin
			ctl_u.upload(ISR_A_AMP, i ? 12'h005 : 12'h265);
			ctl_u.upload(ISR_A_NPIX, i ? 12'h003 : 12'h000);
			ctl_u.frame();
			row(i ? 12'h003 : 12'h000, 1'b0, 0);
			row(i ? 12'h003 : 12'h000, 1'b1, 20);
		end
		`CHK("rows left", 0, exp_q.size())
		$display("test rows done");
		ctl_u.upload(ISR_A_FINE, 12'h083);
		`CHK("fine trim", 8'h83, analog_ctl.fine_dac)
		ctl_u.upload(ISR_A_FINE, 12'h080);
		`CHK("fine matched", 8'h80, analog_ctl.fine_dac)
		ndr_mode <= 1'b1;
		@(posedge clk_sys);
		`CHK("ndr reset bus", 1'b1, analog_ctl.dark_on_reset_buses)
		`CHK("ndr bus", 1'b1, analog_ctl.dark_on_buses)
		ndr_mode <= 1'b0;
		hold_raw <= 1'b1;
		ctl_u.upload(ISR_A_ADC, 12'h014);
		pa = adc_a_raw;
		pb = adc_b_raw;
		settle();
		`CHK("ext single", pa, pix_out)
		`CHK("ndr off", 1'b0, analog_ctl.dark_on_reset_buses)
		ctl_u.upload(ISR_A_ADC, 12'h004);
		settle();
		`CHK("single a", pa, pix_out)
		ctl_u.upload(ISR_A_ADC, 12'h00c);
		settle();
		`CHK("single b", pb, pix_out)
		ctl_u.upload(ISR_A_ADC, 12'h204);
		settle();
		`CHK("gamma", exp_gamma(pa), pix_out)
		ctl_u.upload(ISR_A_ADC, 12'h40c);
		settle();
		`CHK("invert", ~pb, pix_out)
		ctl_u.upload(ISR_A_ADC, 12'h000);
		settle();
		p0 = pix_out;
		@(posedge clk_sys);
		p1 = pix_out;
		`CHK("dual mux", 1'b1, (p0 == pa && p1 == pb) || (p0 == pb && p1 == pa))
		ctl_u.upload(ISR_A_ADC, 12'h008);
		settle();
		p2 = pix_out;
		`CHK("dual swap", (p0 == pa) ? pb : pa, p2)
		hold_raw <= 1'b0;
		$display("test pixels done");
		tally_and_finish();
	end
endmodule : tb
